// ---- tb/acsl_host.sv ----
`timescale 1ns/1ps
`include "acsl_map.svh"
module acsl_host #(
    parameter int HP = 10
) (
    input wire logic mclk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    output logic [7:0] rd_o,
    output logic rd_v_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        rd_o = 8'h00;
        rd_v_o = 1'b0;
    end

    // half period kept above the pin filter minimum of 2 cycles
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
        logic [15:0] b;
        logic [7:0] r;
        b = {cmd, dat};
        r = 8'h00;
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o <= b[i];
            repeat (HP) @(posedge mclk_i);
            sclk_o <= 1'b1;
            r = {r[6:0], miso_i};
            repeat (HP) @(posedge mclk_i);
            sclk_o <= 1'b0;
        end
        repeat (HP) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        // released line has no pull, so it must not keep the last bit
        mosi_o <= ~b[0];
        rd_o <= r;
        rd_v_o <= cmd[`ACSL_CMD_READ_BIT];
        @(posedge mclk_i);
        rd_v_o <= 1'b0;
        repeat (HP) @(posedge mclk_i);
    endtask

    task automatic lock_cfg();
        xfer({3'h0, `ACSL_LOCK_ADDR}, `ACSL_LOCK_KEY);
    endtask

    task automatic unlock_cfg();
        xfer({3'h0, `ACSL_LOCK_ADDR}, `ACSL_UNLOCK_KEY);
    endtask
endmodule // acsl_host

// ---- tb/acsl_regs_props.sv ----
`timescale 1ns/1ps
module acsl_regs_props #(
    parameter int RESET_CYCLES = 16,
    parameter bit TWO_CHANNEL = 1'b0
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic spi_cs_n_i,
    input wire logic data_ready_i,
    input wire logic shared_pin_o,
    input wire logic clock_out_select_o,
    input wire logic converter_power_down_o,
    input wire logic temp_sensor_select_o,
    input wire logic [1:0] output_rate_select_o,
    input wire logic filter_bandwidth_select_o,
    input wire logic software_reset_trigger_o,
    input wire logic reset_in_progress_o,
    input wire logic config_protected_flag_o
);
    logic [7:0] rip_cnt;
    wire [5:0] cfg = {filter_bandwidth_select_o, output_rate_select_o,
        temp_sensor_select_o, converter_power_down_o, clock_out_select_o};

    default clocking @(posedge mclk_i);
    endclocking
    // a frozen clock enable freezes the design, so nothing is judged then
    default disable iff (srst_i || !ce_i);

    // enabled cycles of the current busy stretch; one cycle of slack
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !reset_in_progress_o)
            rip_cnt <= 8'h00;
        else if (ce_i)
            rip_cnt <= rip_cnt + 8'h01;
    end

    sequence clock_mode;
        clock_out_select_o [*2];
    endsequence

    sequence software_reset_trigger_seen;
        software_reset_trigger_o ##1 !software_reset_trigger_o;
    endsequence

    chk_pin_ready: assert property (
        !clock_out_select_o |=> shared_pin_o == $past(data_ready_i))
        else $error("shared pin does not follow data ready");
    chk_pin_clock: assert property (
        clock_mode |=> shared_pin_o != $past(shared_pin_o))
        else $error("shared pin not toggling in clock mode");
    chk_software_reset_trigger_pulse: assert property (
        software_reset_trigger_o |=> !software_reset_trigger_o)
        else $error("software reset trigger longer than one cycle");
    chk_software_reset_trigger_clears: assert property (
        software_reset_trigger_seen |-> reset_in_progress_o && !config_protected_flag_o
        && cfg == {3'h0, TWO_CHANNEL, 2'h0})
        else $error("software reset did not restore defaults");
    chk_variant_temp: assert property (
        TWO_CHANNEL |-> temp_sensor_select_o)
        else $error("two-channel variant not on temperature sensor");
    chk_busy_length: assert property (
        $fell(reset_in_progress_o) |-> rip_cnt >= RESET_CYCLES - 1
        && rip_cnt <= RESET_CYCLES + 1)
        else $error("reset busy flag held for wrong time");
    chk_cfg_locked: assert property (
        config_protected_flag_o && $past(config_protected_flag_o)
        |-> $stable(cfg))
        else $error("configuration changed while protected");
    chk_lock_frame: assert property (
        $changed(config_protected_flag_o) |-> !$past(spi_cs_n_i, 2)
        || $past(software_reset_trigger_o))
        else $error("protection changed outside a frame");
    chk_cfg_frame: assert property (
        $changed(cfg) |-> !$past(spi_cs_n_i, 2)
        || $past(software_reset_trigger_o))
        else $error("configuration changed outside a frame");
endmodule // acsl_regs_props

bind acsl_regs acsl_regs_props #(
    .RESET_CYCLES(RESET_CYCLES),
    .TWO_CHANNEL(TWO_CHANNEL)
) i_props (
    .mclk_i,
    .srst_i,
    .ce_i,
    .spi_cs_n_i,
    .data_ready_i,
    .shared_pin_o,
    .clock_out_select_o,
    .converter_power_down_o,
    .temp_sensor_select_o,
    .output_rate_select_o,
    .filter_bandwidth_select_o,
    .software_reset_trigger_o,
    .reset_in_progress_o,
    .config_protected_flag_o
);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "acsl_map.svh"
module tb_top;
    localparam logic [4:0] A_CFG = `ACSL_CONFIG_ADDR;
    localparam logic [4:0] A_ST = `ACSL_STATUS_ADDR;
    logic mclk_i, srst_i, ce_i, data_ready_i, crc_changed_i;
    logic spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
    logic cos, pd, tsel, tsel2, bw, trig, rip, prot, rv, saw_trig;
    logic [1:0] rate;
    logic [7:0] rd, v;
    logic [7:0] exp_q[$];
    int seed = 59962;
    int n_fail = 0;
    int checked = 0;
    wire miso = spi_miso_oe_o ? spi_miso_o : 1'bz;

    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    acsl_regs #(.RESET_CYCLES(4)) i_dut (
        .mclk_i,
        .srst_i,
        .ce_i,
        .spi_sclk_i,
        .spi_cs_n_i,
        .spi_mosi_i,
        .spi_miso_o,
        .spi_miso_oe_o,
        .data_ready_i,
        .crc_changed_i,
        .shared_pin_o(),
        .clock_out_select_o(cos),
        .converter_power_down_o(pd),
        .temp_sensor_select_o(tsel),
        .output_rate_select_o(rate),
        .filter_bandwidth_select_o(bw),
        .software_reset_trigger_o(trig),
        .reset_in_progress_o(rip),
        .config_protected_flag_o(prot)
    );

    // two-channel variant on the same pins, its read line left open
    acsl_regs #(.RESET_CYCLES(4), .TWO_CHANNEL(1'b1)) i_dut_two (
        .mclk_i,
        .srst_i,
        .ce_i,
        .spi_sclk_i,
        .spi_cs_n_i,
        .spi_mosi_i,
        .spi_miso_o(),
        .spi_miso_oe_o(),
        .data_ready_i,
        .crc_changed_i,
        .shared_pin_o(),
        .clock_out_select_o(),
        .converter_power_down_o(),
        .temp_sensor_select_o(tsel2),
        .output_rate_select_o(),
        .filter_bandwidth_select_o(),
        .software_reset_trigger_o(),
        .reset_in_progress_o(),
        .config_protected_flag_o()
    );

    acsl_host i_host (
        .mclk_i,
        .miso_i(miso),
        .sclk_o(spi_sclk_i),
        .cs_n_o(spi_cs_n_i),
        .mosi_o(spi_mosi_i),
        .rd_o(rd),
        .rd_v_o(rv)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        checked++;
        if (got !== e)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, e);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.xfer({3'h4, a}, 8'h00);
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        i_host.xfer({3'h0, a}, d);
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 64 && rip !== 1'b0; i++)
            @(posedge mclk_i);
    endtask

    task automatic cfg_ports(input logic [7:0] e);
        chk({bw, 1'b0, rate, tsel, pd, 1'b0, cos}, e);
    endtask

    always @(posedge mclk_i)
    begin
        data_ready_i <= 1'($random(seed));
        if (srst_i === 1'b1)
            saw_trig <= 1'b0;
        else if (trig === 1'b1)
            saw_trig <= 1'b1;
        if (rv === 1'b1 && exp_q.size() > 0)
            chk(rd, exp_q.pop_front());
    end

    initial
    begin
        repeat (40000) @(posedge mclk_i);
        n_fail++;
        close_out();
    end

    initial
    begin
        srst_i <= 1'b1;
        ce_i <= 1'b1;
        crc_changed_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        chk({7'h00, rip}, 8'h01);
        // a frozen clock enable must stretch the busy time past its count
        ce_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ce_i <= 1'b1;
        @(posedge mclk_i);
        chk({7'h00, rip}, 8'h01);
        wait_ready();
        rd_reg(A_ST, 8'h00);
        rd_reg(A_CFG, `ACSL_CONFIG_RST);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            v[6] = 1'b0;
            v[5:4] = 2'(i);
            v[3] = i[0];
            wr_reg(A_CFG, v);
            v = v & 8'hBD;
            cfg_ports(v);
            chk({7'h00, tsel2}, 8'h01);
            rd_reg(A_CFG, v);
        end
        $display("config test done");
        i_host.lock_cfg();
        chk({7'h00, prot}, 8'h01);
        rd_reg(A_ST, 8'h04);
        rd_reg(`ACSL_LOCK_ADDR, `ACSL_LOCK_READ);
        wr_reg(A_CFG, ~v);
        wr_reg(A_CFG, 8'h40);
        rd_reg(A_CFG, v);
        chk({7'h00, saw_trig}, 8'h00);
        i_host.unlock_cfg();
        rd_reg(A_ST, 8'h00);
        $display("lock test done");
        wr_reg(A_CFG, 8'h01);
        cfg_ports(8'h01);
        crc_changed_i <= 1'b1;
        @(posedge mclk_i);
        crc_changed_i <= 1'b0;
        rd_reg(A_ST, 8'h02);
        rd_reg(5'h03, `ACSL_UNMAPPED_READ);
        wr_reg(A_CFG, 8'h40);
        chk({7'h00, saw_trig}, 8'h01);
        wait_ready();
        rd_reg(A_ST, 8'h00);
        cfg_ports(8'h00);
        $display("software reset test done");
        close_out();
    end
endmodule // tb_top

// ---- verilog/acsl_map.svh ----
`ifndef ACSL_MAP_SVH
`define ACSL_MAP_SVH

// register addresses carried in the command byte
`define ACSL_ADDR_W 5
`define ACSL_CONFIG_ADDR 5'h08
`define ACSL_STATUS_ADDR 5'h09
`define ACSL_LOCK_ADDR 5'h0A

// protection keys
`define ACSL_LOCK_KEY 8'hCA
`define ACSL_UNLOCK_KEY 8'h9C

// reset and read-back values
`define ACSL_CONFIG_RST 8'h00
`define ACSL_LOCK_READ 8'h00
`define ACSL_UNMAPPED_READ 8'h00
`define ACSL_STATUS_RSVD 5'h00
`define ACSL_RATE_RST 2'h0

// serial frame layout: command byte then data byte, msb first
`define ACSL_CMD_READ_BIT 7
`define ACSL_BIT_CNT_RST 4'h0
`define ACSL_CMD_LAST 4'h7
`define ACSL_FRAME_LAST 4'hF

// software reset busy time in clock cycles
`define ACSL_RESET_CYCLES 16

`endif

// ---- verilog/acsl_pkg.sv ----
package acsl_pkg;

    // configuration register, msb first
    typedef struct packed {
        logic filter_bandwidth_select;
        logic software_reset_trigger;
        logic [1:0] output_rate_select;
        logic temp_sensor_select;
        logic converter_power_down;
        logic reserved;
        logic clock_out_select;
    } acsl_config_t;

    // status register, msb first
    typedef struct packed {
        logic [4:0] reserved;
        logic config_protected_flag;
        logic crc_changed_flag;
        logic reset_in_progress;
    } acsl_status_t;

    // one register access decoded from a serial frame
    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } acsl_access_t;

    typedef enum logic [1:0] {
        ACSL_SPI_IDLE = 2'h0,
        ACSL_SPI_CMD = 2'h1,
        ACSL_SPI_DATA = 2'h3,
        ACSL_SPI_DONE = 2'h2
    } acsl_spi_state_t;

endpackage

// ---- verilog/acsl_regs.sv ----
`timescale 1ns/1ps
`include "acsl_map.svh"

module acsl_regs #(
    parameter bit TWO_CHANNEL = 1'b0,
    parameter int RESET_CYCLES = `ACSL_RESET_CYCLES
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic data_ready_i,
    input wire logic crc_changed_i,
    output logic shared_pin_o,
    output logic clock_out_select_o,
    output logic converter_power_down_o,
    output logic temp_sensor_select_o,
    output logic [1:0] output_rate_select_o,
    output logic filter_bandwidth_select_o,
    output logic software_reset_trigger_o,
    output logic reset_in_progress_o,
    output logic config_protected_flag_o
);

    localparam int CNT_W = $clog2(RESET_CYCLES + 1);
    localparam logic [CNT_W-1:0] RESET_LOAD = CNT_W'(RESET_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    acsl_pkg::acsl_access_t acc;
    logic [7:0] rdata;

    acsl_pkg::acsl_config_t config_reg;
    acsl_pkg::acsl_config_t config_next;
    acsl_pkg::acsl_status_t status;
    logic prot_reg;
    logic prot_next;
    logic crc_flag_reg;
    logic crc_flag_next;
    logic [CNT_W-1:0] rst_cnt_reg;
    logic [CNT_W-1:0] rst_cnt_next;
    logic reset_on_reg;
    logic clk_div_reg;
    logic shared_pin_reg;
    logic temp_sel_reg;
    logic software_reset_trigger_reg;

    logic wr_config;
    logic wr_lock;
    logic sel_config;
    logic sel_status;
    logic sel_lock;
    logic software_reset_trigger_now;
    acsl_pkg::acsl_config_t wr_value;
    logic key_lock_hit;
    logic key_unlock_hit;
    logic rst_cnt_live;
    logic busy_next;
    logic [7:0] cfg_rd_word;
    logic [7:0] status_rd_word;

    // pins from the host pass the three-stage filter
    acsl_sync3 #(
        .W(3),
        .INIT(3'h2)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .d_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
        .q_o({sclk_s, cs_n_s, mosi_s})
    );

    acsl_spi_slave u_spi (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .sclk_i(sclk_s),
        .cs_n_i(cs_n_s),
        .mosi_i(mosi_s),
        .rdata_i(rdata),
        .acc_o(acc),
        .miso_o(spi_miso_o),
        .miso_oe_o(spi_miso_oe_o)
    );

    // address decode
    assign sel_config = (acc.addr == `ACSL_CONFIG_ADDR);
    assign sel_status = (acc.addr == `ACSL_STATUS_ADDR);
    assign sel_lock = (acc.addr == `ACSL_LOCK_ADDR);
    assign wr_config = acc.wr & sel_config & ~prot_reg;
    assign wr_lock = acc.wr & sel_lock;

    // status view
    assign status.reserved = `ACSL_STATUS_RSVD;
    assign status.config_protected_flag = prot_reg;
    assign status.crc_changed_flag = crc_flag_reg;
    assign status.reset_in_progress = reset_on_reg;

    // read mux, lock and unmapped addresses read zero
    assign cfg_rd_word = config_reg;
    assign status_rd_word = status;
    assign rdata = sel_config ? cfg_rd_word :
                   sel_status ? status_rd_word :
                   sel_lock ? `ACSL_LOCK_READ :
                   `ACSL_UNMAPPED_READ;

    // reserved bit is never stored so it cannot steer anything
    always_comb
    begin
        wr_value = acsl_pkg::acsl_config_t'(acc.wdata);
        wr_value.reserved = 1'b0;
    end

    // a stored trigger bit acts on the next cycle
    assign software_reset_trigger_now = config_reg.software_reset_trigger;

    always_comb
    begin
        config_next = config_reg;
        if (software_reset_trigger_now)
            config_next = acsl_pkg::acsl_config_t'(`ACSL_CONFIG_RST);
        else if (wr_config)
            config_next = wr_value;
    end

    // only the two exact keys and a software reset move protection, other values are ignored
    assign key_lock_hit = wr_lock & (acc.wdata == `ACSL_LOCK_KEY);
    assign key_unlock_hit = wr_lock & (acc.wdata == `ACSL_UNLOCK_KEY);

    always_comb
    begin
        prot_next = prot_reg;
        if (software_reset_trigger_now)
            prot_next = 1'b0;
        else if (key_lock_hit)
            prot_next = 1'b1;
        else if (key_unlock_hit)
            prot_next = 1'b0;
    end

    // a change event in the clearing cycle still sets the flag
    assign crc_flag_next = crc_changed_i | (crc_flag_reg & ~software_reset_trigger_now);

    assign rst_cnt_live = (rst_cnt_reg != CNT_ZERO);

    always_comb
    begin
        rst_cnt_next = rst_cnt_reg;
        if (software_reset_trigger_now)
            rst_cnt_next = RESET_LOAD;
        else if (rst_cnt_live)
            rst_cnt_next = rst_cnt_reg - CNT_ONE;
    end

    // busy drops in the cycle the counter reaches zero, not one later
    assign busy_next = (rst_cnt_next != CNT_ZERO);

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            config_reg <= acsl_pkg::acsl_config_t'(`ACSL_CONFIG_RST);
        end
        else if (ce_i)
        begin
            config_reg <= config_next;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            prot_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            prot_reg <= prot_next;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            crc_flag_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            crc_flag_reg <= crc_flag_next;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            rst_cnt_reg <= RESET_LOAD;
        end
        else if (ce_i)
        begin
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            reset_on_reg <= 1'b1;
        end
        else if (ce_i)
        begin
            reset_on_reg <= busy_next;
        end
    end

    // clock function on the shared pin is the clock divided by two
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            clk_div_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            clk_div_reg <= ~clk_div_reg;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            shared_pin_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            shared_pin_reg <= config_reg.clock_out_select ?
                              clk_div_reg : data_ready_i;
        end
    end

    // temperature select (forced high when TWO_CHANNEL) and trigger outputs are re-registered from config_next, each in its own flop
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            temp_sel_reg <= TWO_CHANNEL;
        end
        else if (ce_i)
        begin
            temp_sel_reg <= TWO_CHANNEL |
                            config_next.temp_sensor_select;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            software_reset_trigger_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            software_reset_trigger_reg <= config_next.software_reset_trigger;
        end
    end

    assign shared_pin_o = shared_pin_reg;
    assign clock_out_select_o = config_reg.clock_out_select;
    assign converter_power_down_o = config_reg.converter_power_down;
    assign temp_sensor_select_o = temp_sel_reg;
    assign output_rate_select_o = config_reg.output_rate_select;
    assign filter_bandwidth_select_o =
        config_reg.filter_bandwidth_select;
    assign software_reset_trigger_o = software_reset_trigger_reg;
    assign reset_in_progress_o = reset_on_reg;
    assign config_protected_flag_o = prot_reg;

endmodule // acsl_regs

// ---- verilog/acsl_spi_slave.sv ----
`timescale 1ns/1ps
`include "acsl_map.svh"

module acsl_spi_slave (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] rdata_i,
    output acsl_pkg::acsl_access_t acc_o,
    output logic miso_o,
    output logic miso_oe_o
);

    acsl_pkg::acsl_spi_state_t state_reg;
    logic sclk_prev_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic is_read_reg;
    logic load_reg;
    logic miso_reg;
    logic oe_reg;
    acsl_pkg::acsl_access_t acc_reg;
    logic rise;
    logic fall;
    logic [7:0] shift_in;

    assign rise = sclk_i & ~sclk_prev_reg;
    assign fall = ~sclk_i & sclk_prev_reg;
    assign shift_in = {shift_reg[6:0], mosi_i};

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state_reg <= acsl_pkg::ACSL_SPI_IDLE;
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg <= `ACSL_BIT_CNT_RST;
            shift_reg <= `ACSL_UNMAPPED_READ;
            is_read_reg <= 1'b0;
            load_reg <= 1'b0;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            acc_reg <= '0;
        end
        else if (ce_i)
        begin
            sclk_prev_reg <= sclk_i;
            acc_reg.wr <= 1'b0;
            if (cs_n_i)
            begin
                // a deselect aborts any frame, a partial write is dropped
                state_reg <= acsl_pkg::ACSL_SPI_IDLE;
                oe_reg <= 1'b0;
                load_reg <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    acsl_pkg::ACSL_SPI_IDLE:
                    begin
                        state_reg <= acsl_pkg::ACSL_SPI_CMD;
                        bit_cnt_reg <= `ACSL_BIT_CNT_RST;
                        oe_reg <= 1'b1;
                        miso_reg <= 1'b0;
                    end
                    acsl_pkg::ACSL_SPI_CMD:
                    begin
                        if (rise)
                        begin
                            shift_reg <= shift_in;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == `ACSL_CMD_LAST)
                            begin
                                is_read_reg <= shift_in[`ACSL_CMD_READ_BIT];
                                acc_reg.addr <= shift_in[4:0];
                                load_reg <= 1'b1;
                                state_reg <= acsl_pkg::ACSL_SPI_DATA;
                            end
                        end
                    end
                    acsl_pkg::ACSL_SPI_DATA:
                    begin
                        if (load_reg)
                        begin
                            // address is settled, capture read data
                            load_reg <= 1'b0;
                            if (is_read_reg)
                                shift_reg <= rdata_i;
                        end
                        else if (fall && is_read_reg)
                        begin
                            miso_reg <= shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                        else if (rise)
                        begin
                            if (!is_read_reg)
                                shift_reg <= shift_in;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == `ACSL_FRAME_LAST)
                            begin
                                acc_reg.wr <= ~is_read_reg;
                                acc_reg.wdata <= shift_in;
                                state_reg <= acsl_pkg::ACSL_SPI_DONE;
                            end
                        end
                    end
                    acsl_pkg::ACSL_SPI_DONE:
                    begin
                        state_reg <= acsl_pkg::ACSL_SPI_DONE;
                    end
                    default:
                    begin
                        state_reg <= acsl_pkg::ACSL_SPI_IDLE;
                    end
                endcase
            end
        end
    end

    assign acc_o = acc_reg;
    assign miso_o = miso_reg;
    assign miso_oe_o = oe_reg;

endmodule // acsl_spi_slave

// ---- verilog/acsl_sync3.sv ----
`timescale 1ns/1ps
`include "acsl_map.svh"

module acsl_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] agree;

    // a change is taken only once stages two and three agree
    assign agree = ~(ff2_reg ^ ff3_reg);

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            ff1_reg <= INIT;
            ff2_reg <= INIT;
            ff3_reg <= INIT;
            q_reg <= INIT;
        end
        else if (ce_i)
        begin
            ff1_reg <= d_i;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            q_reg <= (agree & ff3_reg) | (~agree & q_reg);
        end
    end

    assign q_o = q_reg;

endmodule // acsl_sync3
